/* File: hdl/i2cs_pkg.sv */
// Overview of operation
// - the device acknowledges the write-direction id byte, the address byte and the read-direction id byte.
// - the device sends another byte each time the master pulls SDA low in the ninth clock after a byte.
// - the address byte loads the register pointer and the first byte returned comes from that location.
// - the pointer advances by one for every byte transmitted.
// - after delivering location 2Fh of the clock or 7Fh of the memory the pointer wraps to 00h and reading continues on every acknowledge.
// - in battery backup mode all bus traffic is ignored while stored contents are kept.
// - the seven upper bits of the id byte are matched against the clock and memory identifiers; bit 0 set means read.
// - after reset the pointer is zero so a read with no address phase starts at the first location.
// - every byte is shifted most significant bit first in both directions.
package i2cs_pkg;

  localparam logic [7:0] I2CS_PTR_RST   = 8'h00;
  localparam logic [7:0] I2CS_RTC_TOP   = 8'h2F;
  localparam logic [7:0] I2CS_SRAM_TOP  = 8'h7F;
  localparam logic [2:0] I2CS_BIT_LAST  = 3'h7;
  localparam logic [2:0] I2CS_BIT_RST   = 3'h0;
  localparam logic [7:0] I2CS_BYTE_RST  = 8'h00;
  localparam logic       I2CS_RW_READ   = 1'b1;
  // identifier defaults are arbitrary values
  localparam logic [6:0] I2CS_ID_RTC    = 7'h3A;
  localparam logic [6:0] I2CS_ID_SRAM   = 7'h2B;
  localparam int         I2CS_SYNC_W    = 3;

  typedef enum logic [2:0] {
    I2CS_ST_IDLE = 3'b000,
    I2CS_ST_RX   = 3'b001,
    I2CS_ST_ACK  = 3'b010,
    I2CS_ST_TX   = 3'b011,
    I2CS_ST_MACK = 3'b100
  } i2cs_state_t;

  typedef enum logic [1:0] {
    I2CS_RX_DEV  = 2'b00,
    I2CS_RX_WORD = 2'b01,
    I2CS_RX_DATA = 2'b10
  } i2cs_rx_kind_t;

  // write request toward the register store
  typedef struct packed {
    logic       space;
    logic [7:0] addr;
    logic [7:0] data;
  } i2cs_wr_t;

endpackage

/* File: hdl/i2cs_sync.sv */
`timescale 1ns/10ps
module i2cs_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // two stages; only the second stage leaves this module
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

/* File: hdl/i2cs_slave.sv */
`timescale 1ns/10ps
module i2cs_slave
  import i2cs_pkg::*;
#(
  parameter logic [6:0] ID_RTC  = I2CS_ID_RTC,
  parameter logic [6:0] ID_SRAM = I2CS_ID_SRAM
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       bat_mode_i,
  output logic [7:0]      rd_addr_o,
  output logic            rd_space_o,
  input  wire logic [7:0] rd_data_i,
  output logic            wr_en_o,
  output i2cs_wr_t        wr_o
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisation and bus event detection

  logic [2:0]    sync_w;
  logic          scl_s;
  logic          sda_s;
  logic          bat_s;
  logic          scl_d_r;
  logic          sda_d_r;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_det;
  logic          stop_det;

  i2cs_sync #(
    .W (I2CS_SYNC_W)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    ({bat_mode_i, sda_i, scl_i}),
    .sync_o     (sync_w)
  );

  assign scl_s = sync_w[0];
  assign sda_s = sync_w[1];
  assign bat_s = sync_w[2];

  // delayed copies for edge finding; bus idles high
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  // sda moving while scl stays high marks start and stop
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // pointer arithmetic shared by the read and write paths

  function automatic logic [7:0] ptr_next(input logic [7:0] ptr, input logic space);
    logic [7:0] top;
    top = space ? I2CS_SRAM_TOP : I2CS_RTC_TOP;
    if (ptr >= top) begin
      ptr_next = I2CS_PTR_RST;
    end else begin
      ptr_next = ptr + 8'h01;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // byte engine

  i2cs_state_t   state_r;
  i2cs_state_t   after_ack_r;
  i2cs_rx_kind_t kind_r;
  logic [7:0]    shreg_r;
  logic [2:0]    bitcnt_r;
  logic          full_r;
  logic          mack_r;
  logic [7:0]    ptr_r;
  logic          space_r;
  logic          sda_oe_r;
  logic          wr_en_r;
  i2cs_wr_t      wr_r;
  logic          id_rtc_hit;
  logic          id_sram_hit;

  assign id_rtc_hit  = (shreg_r[7:1] == ID_RTC);
  assign id_sram_hit = (shreg_r[7:1] == ID_SRAM);

  // sequencer; start and stop override any byte in flight, backup mode wins over both
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r     <= I2CS_ST_IDLE;
      after_ack_r <= I2CS_ST_IDLE;
      kind_r      <= I2CS_RX_DEV;
      shreg_r     <= I2CS_BYTE_RST;
      bitcnt_r    <= I2CS_BIT_RST;
      full_r      <= 1'b0;
      mack_r      <= 1'b0;
      ptr_r       <= I2CS_PTR_RST;
      space_r     <= 1'b0;
      sda_oe_r    <= 1'b0;
    end else if (bat_s) begin
      state_r  <= I2CS_ST_IDLE;
      sda_oe_r <= 1'b0;
      full_r   <= 1'b0;
    end else if (start_det) begin
      // a repeated start keeps the pointer, which carries the dummy write address
      state_r  <= I2CS_ST_RX;
      kind_r   <= I2CS_RX_DEV;
      bitcnt_r <= I2CS_BIT_RST;
      full_r   <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      state_r  <= I2CS_ST_IDLE;
      sda_oe_r <= 1'b0;
      full_r   <= 1'b0;
    end else begin
      unique case (state_r)
        I2CS_ST_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        I2CS_ST_RX: begin
          if (scl_rise && !full_r) begin
            shreg_r  <= {shreg_r[6:0], sda_s};
            bitcnt_r <= bitcnt_r + 3'h1;
            full_r   <= (bitcnt_r == I2CS_BIT_LAST);
          end else if (scl_fall && full_r) begin
            full_r   <= 1'b0;
            bitcnt_r <= I2CS_BIT_RST;
            unique case (kind_r)
              I2CS_RX_DEV: begin
                if (id_rtc_hit || id_sram_hit) begin
                  space_r     <= id_sram_hit;
                  sda_oe_r    <= 1'b1;
                  state_r     <= I2CS_ST_ACK;
                  after_ack_r <= (shreg_r[0] == I2CS_RW_READ) ? I2CS_ST_TX : I2CS_ST_RX;
                  kind_r      <= I2CS_RX_WORD;
                end else begin
                  state_r <= I2CS_ST_IDLE; // not addressed: stay off the bus
                end
              end
              I2CS_RX_WORD: begin
                ptr_r       <= shreg_r;
                sda_oe_r    <= 1'b1;
                state_r     <= I2CS_ST_ACK;
                after_ack_r <= I2CS_ST_RX;
                kind_r      <= I2CS_RX_DATA;
              end
              default: begin
                ptr_r       <= ptr_next(ptr_r, space_r);
                sda_oe_r    <= 1'b1;
                state_r     <= I2CS_ST_ACK;
                after_ack_r <= I2CS_ST_RX;
              end
            endcase
          end
        end
        I2CS_ST_ACK: begin
          // the ack is held through the ninth clock; its falling edge releases sda or, for a read, puts out the first data bit
          if (scl_fall) begin
            if (after_ack_r == I2CS_ST_TX) begin
              shreg_r  <= rd_data_i;
              sda_oe_r <= ~rd_data_i[7];
              state_r  <= I2CS_ST_TX;
            end else begin
              sda_oe_r <= 1'b0;
              state_r  <= I2CS_ST_RX;
            end
          end
        end
        I2CS_ST_TX: begin
          if (scl_fall) begin
            if (bitcnt_r == I2CS_BIT_LAST) begin
              sda_oe_r <= 1'b0; // free sda for the master's ack
              bitcnt_r <= I2CS_BIT_RST;
              ptr_r    <= ptr_next(ptr_r, space_r);
              state_r  <= I2CS_ST_MACK;
            end else begin
              shreg_r  <= {shreg_r[6:0], 1'b0};
              sda_oe_r <= ~shreg_r[6];
              bitcnt_r <= bitcnt_r + 3'h1;
            end
          end
        end
        I2CS_ST_MACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_s;
          end else if (scl_fall) begin
            if (mack_r) begin
              shreg_r  <= rd_data_i;
              sda_oe_r <= ~rd_data_i[7];
              state_r  <= I2CS_ST_TX;
            end else begin
              sda_oe_r <= 1'b0;
              state_r  <= I2CS_ST_IDLE;
            end
          end
        end
        default: begin
          state_r  <= I2CS_ST_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write strobe for data bytes of a write, one cycle per byte

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_en_r <= 1'b0;
      wr_r    <= '0;
    end else begin
      wr_en_r <= 1'b0;
      if (!bat_s && !start_det && !stop_det && state_r == I2CS_ST_RX &&
          scl_fall && full_r && kind_r == I2CS_RX_DATA) begin
        wr_en_r    <= 1'b1;
        wr_r.space <= space_r;
        wr_r.addr  <= ptr_r;
        wr_r.data  <= shreg_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; sda is only ever pulled low, the enable carries the level

  assign sda_o      = 1'b0;
  assign sda_oe_o   = sda_oe_r;
  assign rd_addr_o  = ptr_r;
  assign rd_space_o = space_r;
  assign wr_en_o    = wr_en_r;
  assign wr_o       = wr_r;

endmodule

/* File: bench/i2cs_slave_sva.sv */
`timescale 1ns/10ps
module i2cs_slave_sva (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       bat_mode_i,
  input wire logic [7:0] rd_addr_o,
  input wire logic       rd_space_o,
  input wire logic       wr_en_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // reset must be seen even while reset itself is low
  reset_state_a: assert property (disable iff (1'b0) !rst_n_i |-> !sda_oe_o && rd_addr_o == 8'h00)
    else $error("state not cleared in reset");
  bat_quiet_a: assert property (bat_mode_i [*5] |-> !sda_oe_o)
    else $error("bus driven in backup mode");
  ack_hold_a: assert property ($rose(sda_oe_o) && !bat_mode_i |=> sda_oe_o [*8])
    else $error("acknowledge cut short");
  low_phase_a: assert property ($changed(sda_oe_o) && !bat_mode_i |-> !scl_i)
    else $error("sda moved while scl high");
  ptr_step_a: assert property ($changed(rd_addr_o) |-> !scl_i)
    else $error("pointer moved while scl high");
  // a read step is the only pointer move that leaves sda released; loads and write steps raise the ack
  clk_wrap_a: assert property ($changed(rd_addr_o) && !sda_oe_o && $past(rd_addr_o) == 8'h2F && !rd_space_o |-> rd_addr_o == 8'h00)
    else $error("clock pointer did not wrap to zero");
  mem_wrap_a: assert property ($changed(rd_addr_o) && !sda_oe_o && $past(rd_addr_o) == 8'h7F && rd_space_o |-> rd_addr_o == 8'h00)
    else $error("memory pointer did not wrap to zero");
  wr_pulse_a: assert property (wr_en_o |=> !wr_en_o)
    else $error("write strobe longer than one cycle");
  // open drain: the pin may only ever be pulled low
  drive_low_a: assert property (sda_oe_o |-> sda_o == 1'b0)
    else $error("sda driven high");
endmodule
bind i2cs_slave i2cs_slave_sva u_i2cs_slave_sva (.core_clk_i, .rst_n_i, .scl_i, .sda_o, .sda_oe_o, .bat_mode_i,
  .rd_addr_o, .rd_space_o, .wr_en_o);

/* File: bench/i2cs_master_model.sv */
`timescale 1ns/10ps
module i2cs_master_model (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_dn_o
);
  // both lines released; scl stands still high between frames
  initial begin
    scl_o    = 1'b1;
    sda_dn_o = 1'b0;
  end
  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_dn_o = 1'b0;
    #20 scl_o = 1'b1;
    #20 sda_dn_o = 1'b1;
    #20 scl_o = 1'b0;
    #20;
  endtask
  task automatic stop();
    sda_dn_o = 1'b1;
    #20 scl_o = 1'b1;
    #20 sda_dn_o = 1'b0;
    #40;
  endtask
  // data set mid low phase so the device sees it settled well before the rise
  task automatic bit_out(input logic b);
    sda_dn_o = ~b;
    #20 scl_o = 1'b1;
    #40 scl_o = 1'b0;
    #20;
  endtask
  task automatic bit_in(output logic b);
    sda_dn_o = 1'b0;
    #20 scl_o = 1'b1;
    #20 b = sda_i;
    #20 scl_o = 1'b0;
    #20;
  endtask
  // byte to the device msb first, then its acknowledge
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(b);
    ack = ~b;
  endtask
  // byte from the device; mack low leaves sda high to end the stream
  task automatic get_byte(input logic mack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(~mack);
  endtask
endmodule

/* File: bench/i2cs_slave_tb.sv */
`timescale 1ns/10ps
module i2cs_slave_tb
  import i2cs_pkg::*;
;
  logic       clk;
  logic       rst_n;
  logic       bat;
  logic       scl;
  logic       dn;
  logic       oe;
  logic       sp;
  logic       wr_en;
  logic [7:0] addr;
  logic [7:0] rdat;
  i2cs_wr_t   wr;
  i2cs_wr_t   wr_seen;
  int         fail_count;
  int         tests_run;
  wire        sda = ~(dn | oe);
  initial clk = 1'b0;
  always #2 clk = ~clk;
  // store stand-in: each location returns a pattern tied to its address
  assign rdat = addr ^ {sp, 7'h5A};
  always @(posedge clk) if (wr_en) wr_seen <= wr;
  i2cs_slave u_i2cs_slave (.core_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(oe), .bat_mode_i(bat), .rd_addr_o(addr), .rd_space_o(sp), .rd_data_i(rdat),
    .wr_en_o(wr_en), .wr_o(wr));
  i2cs_master_model u_mst (.sda_i(sda), .scl_o(scl), .sda_dn_o(dn));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [16:0] e, input logic [16:0] s);
    tests_run++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic end_sim();
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // read of n bytes, with or without the address phase
  task automatic rd_seq(input logic [6:0] id, input logic s, input logic aph, input logic [7:0] a0, input int n);
    logic       ack;
    logic [7:0] d;
    logic [7:0] a;
    a = a0;
    u_mst.start();
    if (aph) begin
      u_mst.put_byte({id, 1'b0}, ack);
      chk("ack_id_wr", 17'h00001, 17'(ack));
      u_mst.put_byte(a0, ack);
      chk("ack_addr", 17'h00001, 17'(ack));
      u_mst.start();
    end
    u_mst.put_byte({id, 1'b1}, ack);
    chk("ack_id_rd", 17'h00001, 17'(ack));
    for (int k = 0; k < n; k++) begin
      u_mst.get_byte(k != n - 1, d);
      chk("rd_data", 17'(a ^ {s, 7'h5A}), 17'(d));
      a = (a == (s ? I2CS_SRAM_TOP : I2CS_RTC_TOP)) ? 8'h00 : a + 8'h01;
    end
    chk("rd_space", 17'(s), 17'(sp));
    u_mst.stop();
  endtask
  task automatic t_cur_rst();
    rd_seq(I2CS_ID_RTC, 1'b0, 1'b0, 8'h00, 2);
  endtask
  task automatic t_rtc_wrap();
    rd_seq(I2CS_ID_RTC, 1'b0, 1'b1, 8'h2E, 4);
  endtask
  task automatic t_mem_wrap();
    rd_seq(I2CS_ID_SRAM, 1'b1, 1'b1, 8'h7E, 3);
  endtask
  // write one byte, then a plain read must carry on past it
  task automatic t_write();
    logic ack;
    u_mst.start();
    u_mst.put_byte({I2CS_ID_SRAM, 1'b0}, ack);
    u_mst.put_byte(8'h05, ack);
    u_mst.put_byte(8'hC3, ack);
    chk("ack_wdata", 17'h00001, 17'(ack));
    u_mst.stop();
    chk("wr", 17'h105C3, wr_seen);
    rd_seq(I2CS_ID_SRAM, 1'b1, 1'b0, 8'h06, 1);
  endtask
  task automatic t_bad_id();
    logic ack;
    u_mst.start();
    u_mst.put_byte({7'h11, 1'b1}, ack);
    chk("ack_bad_id", 17'h00000, 17'(ack));
    u_mst.stop();
  endtask
  // backup mode hides the device; it answers again once power returns
  task automatic t_backup();
    logic ack;
    @(posedge clk) #1 bat = 1'b1;
    // keep every bus change one step after the clock edge
    repeat (8) @(posedge clk);
    #1;
    u_mst.start();
    u_mst.put_byte({I2CS_ID_RTC, 1'b1}, ack);
    chk("ack_backup", 17'h00000, 17'(ack));
    u_mst.stop();
    @(posedge clk) #1 bat = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rd_seq(I2CS_ID_RTC, 1'b0, 1'b1, 8'h10, 1);
  endtask
  initial begin
    fail_count = 0;
    tests_run  = 0;
    rst_n      = 1'b1;
    bat        = 1'b0;
    // reset falls after time zero so the design sees a clean edge
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    // model delays are whole clock multiples, so this offset holds for the run
    #1;
    t_cur_rst();
    t_rtc_wrap();
    t_mem_wrap();
    t_write();
    t_bad_id();
    t_backup();
    end_sim();
  end
  // a stuck handshake would otherwise hang the run
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
endmodule
